// ==== src/scp_pkg.sv ====
// Constants and carrier types of the serial port configuration block.
// Assumes a 32-bit APB with registers in the low 16 bits of each word.
package scp_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] CTL_ONE_OFFSET = 8'h00;
	localparam logic [7:0] CTL_TWO_OFFSET = 8'h04;
	localparam logic [15:0] CTL_ONE_RESET = 16'h0000;
	localparam logic [15:0] CTL_TWO_RESET = 16'h0000;
	// Writable bits of each control register
	localparam logic [15:0] CTL_ONE_MASK = 16'h1FFF;
	localparam logic [15:0] CTL_TWO_MASK = 16'hE003;
	localparam int unsigned RATIO_W = 10;
	localparam logic [2:0] SEC_BASE = 3'h0;
	localparam logic [3:0] SEC_SPAN = 4'h8;
	localparam logic [RATIO_W-1:0] PRIM_DIV1 = 10'h001;
	localparam logic [RATIO_W-1:0] PRIM_DIV4 = 10'h004;
	localparam logic [RATIO_W-1:0] PRIM_DIV16 = 10'h010;
	localparam logic [RATIO_W-1:0] PRIM_DIV64 = 10'h040;
	localparam logic [4:0] BITS_WIDE = 5'h10;
	localparam logic [4:0] BITS_BYTE = 5'h08;

	typedef struct packed {
		logic [2:0] unused;
		logic clock_pin_disable;
		logic out_pin_disable;
		logic word_wide;
		logic sample_late;
		logic clock_edge;
		logic select_pin_enable;
		logic clock_idle_high;
		logic master_enable;
		logic [2:0] secondary_divider_sel;
		logic [1:0] primary_divider_sel;
	} scp_ctl_one_type;

	typedef struct packed {
		logic framed_enable;
		logic frame_sync_direction;
		logic frame_sync_polarity;
		logic [10:0] unused;
		logic frame_sync_edge;
		logic enhanced_buffer_enable;
	} scp_ctl_two_type;

	typedef struct packed {
		logic in;
		logic out;
		logic oe;
	} scp_pin_type;
endpackage

// ==== src/scp_config.sv ====
// Serial port clock prescaler, framing control and APB register file.
// Assumes pins arrive asynchronous to pclk; start_frame is on pclk.
//
// Functional notes
// - The secondary divide ratio is eight minus its three-bit field.
// - Primary field 11,10,01,00 divides by 1,4,16,64 respectively.
// - The dividers only act in master mode; slaves use the external clock.
// - Master serial clock period is the product of both ratios in pclk; a product of 1 leaves the clock pin idle.
// - In framed mode the clock edge bit is ignored; software keeps it 0.
// - Control two bit 15 enables framed transfers.
// - Control two bit 14 set makes frame sync an input, clear an output.
// - Control two bit 13 sets frame sync active-high, clear active-low.
// - Bit 1 set puts sync on the first bit clock, clear one clock ahead.
// - Bit 0 set selects the enhanced buffer, clear the single buffer.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps

module scp_config (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [scp_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	input wire logic select_pin_in,
	output logic select_pin_out,
	output logic select_pin_oe,
	output logic out_pin_enable,
	input wire logic start_frame,
	output logic bit_tick,
	output logic first_bit,
	output logic frame_sync_seen,
	output logic clock_edge_eff,
	output logic enhanced_buffer_enable,
	output logic master_mode
);
	scp_pkg::scp_ctl_one_type ctl1_r;
	scp_pkg::scp_ctl_two_type ctl2_r;
	logic [31:0] prdata_r;
	logic [scp_pkg::RATIO_W-1:0] prim_ratio;
	logic [scp_pkg::RATIO_W-1:0] sec_ratio;
	logic [scp_pkg::RATIO_W-1:0] ratio;
	logic [scp_pkg::RATIO_W-1:0] cnt_r;
	logic [scp_pkg::RATIO_W-1:0] cnt_nxt;
	logic rate_tick;
	logic sck_out_r;
	logic sck_s1_r, sck_s2_r, sck_s3_r;
	logic sel_s1_r, sel_s2_r, sel_s3_r;
	logic framed_master;
	logic framed_slave;
	logic fs_active_r;
	logic [4:0] bits_r;
	logic [4:0] word_bits;
	logic wr_en, rd_setup, hit_one, hit_two;
	typedef enum {ST_IDLE, ST_ARM, ST_LEAD, ST_BITS} scp_state_type;
	scp_state_type state_r;

	// Register access
	assign hit_one = (paddr == scp_pkg::CTL_ONE_OFFSET);
	assign hit_two = (paddr == scp_pkg::CTL_TWO_OFFSET);
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	// Zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~(hit_one | hit_two);
	assign prdata = prdata_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl1_r <= scp_pkg::CTL_ONE_RESET;
		end else if (wr_en && hit_one) begin
			ctl1_r <= pwdata[15:0] & scp_pkg::CTL_ONE_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl2_r <= scp_pkg::CTL_TWO_RESET;
		end else if (wr_en && hit_two) begin
			ctl2_r <= pwdata[15:0] & scp_pkg::CTL_TWO_MASK;
		end
	end

	// Read data is loaded in the setup cycle so it is stable in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (rd_setup) begin
			if (hit_one) begin
				prdata_r <= {16'h0000, ctl1_r};
			end else if (hit_two) begin
				prdata_r <= {16'h0000, ctl2_r & scp_pkg::CTL_TWO_MASK};
			end else begin
				prdata_r <= 32'h0000_0000;
			end
		end
	end

	// Prescaler ratios
	always_comb begin
		case (ctl1_r.primary_divider_sel)
		2'h3: prim_ratio = scp_pkg::PRIM_DIV1;
		2'h2: prim_ratio = scp_pkg::PRIM_DIV4;
		2'h1: prim_ratio = scp_pkg::PRIM_DIV16;
		default: prim_ratio = scp_pkg::PRIM_DIV64;
		endcase
	end

	assign sec_ratio = scp_pkg::RATIO_W'(scp_pkg::SEC_SPAN) -
		scp_pkg::RATIO_W'(ctl1_r.secondary_divider_sel);
	assign ratio = scp_pkg::RATIO_W'(prim_ratio * sec_ratio);
	assign master_mode = ctl1_r.master_enable;

	// The counter is held in slave mode so no local clock is made
	always_comb begin
		cnt_nxt = cnt_r + 1'b1;
		if (!master_mode || cnt_r >= ratio - 1'b1) begin
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign rate_tick = master_mode && (cnt_r >= ratio - 1'b1);

	// Ratio 1 is not a usable pin rate; it and slave mode leave it idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_out_r <= 1'b0;
		end else if (master_mode && ratio > scp_pkg::PRIM_DIV1) begin
			sck_out_r <= ctl1_r.clock_idle_high ^
				(cnt_nxt < (ratio >> 1));
		end else begin
			sck_out_r <= ctl1_r.clock_idle_high;
		end
	end

	assign serial_clock_pin_out = sck_out_r;
	assign serial_clock_pin_oe = master_mode &
		~ctl1_r.clock_pin_disable;
	assign out_pin_enable = ~ctl1_r.out_pin_disable;

	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_s1_r <= 1'b0;
			sck_s2_r <= 1'b0;
			sck_s3_r <= 1'b0;
			sel_s1_r <= 1'b0;
			sel_s2_r <= 1'b0;
			sel_s3_r <= 1'b0;
		end else begin
			sck_s1_r <= serial_clock_pin_in;
			sck_s2_r <= sck_s1_r;
			sck_s3_r <= sck_s2_r;
			sel_s1_r <= select_pin_in;
			sel_s2_r <= sel_s1_r;
			sel_s3_r <= sel_s2_r;
		end
	end

	// Slave: one pulse per external clock period
	assign bit_tick = master_mode ? rate_tick :
		(sck_s2_r & ~sck_s3_r);

	assign clock_edge_eff = ctl1_r.clock_edge &
		~ctl2_r.framed_enable;
	assign enhanced_buffer_enable = ctl2_r.enhanced_buffer_enable;

	assign framed_master = ctl2_r.framed_enable &
		~ctl2_r.frame_sync_direction;
	assign framed_slave = ctl2_r.framed_enable &
		ctl2_r.frame_sync_direction;

	// Incoming sync: asserted level edge after polarity correction
	assign frame_sync_seen = framed_slave &
		((sel_s2_r ^ ~ctl2_r.frame_sync_polarity) &
		~(sel_s3_r ^ ~ctl2_r.frame_sync_polarity));

	assign word_bits = ctl1_r.word_wide ? scp_pkg::BITS_WIDE :
		scp_pkg::BITS_BYTE;

	// Frame sequencer for the frame master
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
		end else if (!framed_master || !master_mode) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
			ST_IDLE: begin
				if (start_frame) begin
					state_r <= ST_ARM;
				end
			end
			ST_ARM: begin
				if (rate_tick) begin
					state_r <= ctl2_r.frame_sync_edge ? ST_BITS :
						ST_LEAD;
				end
			end
			ST_LEAD: begin
				if (rate_tick) begin
					state_r <= ST_BITS;
				end
			end
			ST_BITS: begin
				if (rate_tick && bits_r == 5'h01) begin
					state_r <= ST_IDLE;
				end
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	assign first_bit = rate_tick &&
		((state_r == ST_ARM && ctl2_r.frame_sync_edge) ||
		state_r == ST_LEAD);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bits_r <= 5'h00;
		end else if (first_bit) begin
			bits_r <= word_bits;
		end else if (rate_tick && bits_r != 5'h00) begin
			bits_r <= bits_r - 5'h01;
		end
	end

	// Sync lasts one serial clock period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fs_active_r <= 1'b0;
		end else if (!framed_master || !master_mode) begin
			fs_active_r <= 1'b0;
		end else if (rate_tick) begin
			fs_active_r <= (state_r == ST_ARM);
		end
	end

	assign select_pin_oe = framed_master;
	assign select_pin_out = fs_active_r ~^
		ctl2_r.frame_sync_polarity;

	// Helper: pclk cycles since the last rate tick
	logic [scp_pkg::RATIO_W-1:0] gap_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_r <= '0;
		end else if (rate_tick || !master_mode) begin
			gap_r <= '0;
		end else begin
			gap_r <= gap_r + 1'b1;
		end
	end

	sequence s_two_ticks;
		rate_tick ##1 (!rate_tick && $stable(ratio))[*1] ##0 1'b1;
	endsequence

	property p_tick_spacing;
		@(posedge pclk) disable iff (!presetn)
		rate_tick && $stable(ratio) && gap_r != 0 |->
			gap_r == ratio - 1'b1;
	endproperty
	a_tick_spacing: assert property (p_tick_spacing)
		else $error("serial clock period differs from divide product");

	property p_sec_ratio;
		@(posedge pclk) disable iff (!presetn)
		ctl1_r.secondary_divider_sel == 3'h7 |-> sec_ratio == 10'h001;
	endproperty
	a_sec_ratio: assert property (p_sec_ratio)
		else $error("secondary code 111 must divide by one");

	property p_prim_ratio;
		@(posedge pclk) disable iff (!presetn)
		ctl1_r.primary_divider_sel == 2'h0 &&
		ctl1_r.secondary_divider_sel == 3'h0 |-> ratio == 10'h200;
	endproperty
	a_prim_ratio: assert property (p_prim_ratio)
		else $error("slowest setting must divide by 512");

	property p_slave_quiet;
		@(posedge pclk) disable iff (!presetn)
		!master_mode |-> !rate_tick && !serial_clock_pin_oe;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet)
		else $error("divider active in slave mode");

	property p_edge_ignored;
		@(posedge pclk) disable iff (!presetn)
		ctl2_r.framed_enable |-> !clock_edge_eff;
	endproperty
	a_edge_ignored: assert property (p_edge_ignored)
		else $error("clock edge bit used in framed mode");

	property p_unframed;
		@(posedge pclk) disable iff (!presetn)
		!ctl2_r.framed_enable |-> !select_pin_oe ##1 !fs_active_r;
	endproperty
	a_unframed: assert property (p_unframed)
		else $error("frame sync active with framing disabled");

	property p_sync_input;
		@(posedge pclk) disable iff (!presetn)
		ctl2_r.frame_sync_direction |-> !select_pin_oe;
	endproperty
	a_sync_input: assert property (p_sync_input)
		else $error("select pin driven while sync is an input");

	property p_sync_polarity;
		@(posedge pclk) disable iff (!presetn)
		select_pin_oe |->
			select_pin_out == (fs_active_r == ctl2_r.frame_sync_polarity);
	endproperty
	a_sync_polarity: assert property (p_sync_polarity)
		else $error("frame sync level has wrong polarity");

	sequence s_lead_sync;
		fs_active_r ##1 !fs_active_r;
	endsequence

	property p_sync_ahead;
		@(posedge pclk) disable iff (!presetn)
		first_bit && !ctl2_r.frame_sync_edge && $stable(ctl2_r) |->
			s_lead_sync;
	endproperty
	a_sync_ahead: assert property (p_sync_ahead)
		else $error("leading sync not one clock before first bit");

	property p_sync_with;
		@(posedge pclk) disable iff (!presetn)
		first_bit && ctl2_r.frame_sync_edge |=> fs_active_r;
	endproperty
	a_sync_with: assert property (p_sync_with)
		else $error("sync does not coincide with first bit");

	property p_buffer_sel;
		@(posedge pclk) disable iff (!presetn)
		wr_en && hit_two |=>
			enhanced_buffer_enable == $past(pwdata[0]);
	endproperty
	a_buffer_sel: assert property (p_buffer_sel)
		else $error("buffer select does not follow bit 0");

	property p_reserved_zero;
		@(posedge pclk) disable iff (!presetn)
		rd_setup && hit_two |=> prdata[12:2] == 11'h000 &&
			prdata[31:16] == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("unimplemented control bits read nonzero");
endmodule // scp_config

// ==== bench/scp_far_end.sv ====
// Far-end serial peer: makes the link clock and frame sync for a slave port.
// Assumes pclk as its time base; the link clock stands still outside frames.
`timescale 1ns/1ps

module scp_far_end #(
	parameter int HALF = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic sync_req,
	output logic sck,
	output logic sel
);
	int cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck <= 1'b0;
			cnt <= 0;
		end else if (!run) begin
			// Clock idles low between frames
			sck <= 1'b0;
			cnt <= 0;
		end else if (cnt == HALF - 1) begin
			sck <= ~sck;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end

	// Frame sync pulse driven only on request
	assign sel = sync_req;
endmodule // scp_far_end

// ==== bench/tb_spi_clock_prescale_and_framing.sv ====
// Bench for the serial port configuration block, APB master plus far peer.
// Assumes zero-wait APB and bit_tick/first_bit as frame timing hooks.
`timescale 1ns/1ps

module tb_spi_clock_prescale_and_framing;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, start_frame = 1'b0, run = 1'b0, sync_req = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, sck, sel, sck_out, sck_oe, sel_out, sel_oe;
	logic out_en, bit_tick, first_bit, fs_seen, edge_eff, ebuf, mst;
	int err_count = 0, cmp_count = 0, cyc = 0, n, i;
	logic [15:0] rc [6] = '{16'h003E, 16'h003B, 16'h0023, 16'h0035,
		16'h003C, 16'h002E};
	int rp [6] = '{4, 2, 8, 48, 64, 20};

	always #10 pclk = ~pclk;

	scp_config dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_clock_pin_in(sck), .serial_clock_pin_out(sck_out),
		.serial_clock_pin_oe(sck_oe), .select_pin_in(sel),
		.select_pin_out(sel_out), .select_pin_oe(sel_oe),
		.out_pin_enable(out_en), .start_frame(start_frame),
		.bit_tick(bit_tick), .first_bit(first_bit),
		.frame_sync_seen(fs_seen), .clock_edge_eff(edge_eff),
		.enhanced_buffer_enable(ebuf), .master_mode(mst));

	scp_far_end #(.HALF(5)) peer (.pclk(pclk), .presetn(presetn), .run(run),
		.sync_req(sync_req), .sck(sck), .sel(sel));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			err_count++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Cycles between two sampled events, each wait bounded by the timeout
	task automatic gap(ref logic a, ref logic b, output int c);
		do @(posedge pclk); while (a !== 1'b1);
		c = 0;
		do begin
			@(posedge pclk);
			c++;
		end while (b !== 1'b1);
	endtask

	// Waits for one sampled high level, bounded by the timeout
	task automatic wait_hi(ref logic a);
		do @(posedge pclk); while (a !== 1'b1);
	endtask

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, scp_pkg::CTL_ONE_OFFSET, 0);
		chk(rd, 32'h0000_0000);
		apb(0, scp_pkg::CTL_TWO_OFFSET, 0);
		chk(rd, 32'h0000_0000);
		apb(1, 8'h0C, 32'h0000_FFFF);
		chk({31'h0, err}, 32'h1);
		for (i = 0; i < 6; i++) begin
			apb(1, scp_pkg::CTL_ONE_OFFSET, {16'h0, rc[i]});
			gap(bit_tick, bit_tick, n);
			gap(bit_tick, bit_tick, n);
			chk(n, rp[i]);
			@(posedge pclk);
			chk({sck_out, sck_oe}, 2'b11);
		end
		apb(1, scp_pkg::CTL_TWO_OFFSET, 32'hFFFF_FFFF);
		apb(0, scp_pkg::CTL_TWO_OFFSET, 0);
		chk(rd, 32'h0000_E003);
		chk({ebuf, sel_oe}, 2'b10);
		// Framed master, sync on first bit, active low; edge bit must not act
		apb(1, scp_pkg::CTL_TWO_OFFSET, 32'h0000_8002);
		apb(1, scp_pkg::CTL_ONE_OFFSET, 32'h0000_013E);
		chk({sel_oe, edge_eff, ebuf}, 3'b100);
		start_frame <= 1'b1;
		@(posedge pclk);
		start_frame <= 1'b0;
		wait_hi(first_bit);
		chk(sel_out, 1'b1);
		repeat (2) @(posedge pclk);
		chk(sel_out, 1'b0);
		// Wait for the eight-bit frame to finish before reconfiguring
		repeat (40) @(posedge pclk);
		// Framed master, sync one clock ahead, active high
		apb(1, scp_pkg::CTL_TWO_OFFSET, 32'h0000_A000);
		apb(1, scp_pkg::CTL_ONE_OFFSET, 32'h0000_003E);
		start_frame <= 1'b1;
		@(posedge pclk);
		start_frame <= 1'b0;
		gap(sel_out, first_bit, n);
		chk(n, 3);
		@(posedge pclk);
		chk(sel_out, 1'b0);
		// Slave: external clock sets the pace, dividers have no effect
		apb(1, scp_pkg::CTL_TWO_OFFSET, 32'h0000_E000);
		apb(1, scp_pkg::CTL_ONE_OFFSET, 32'h0000_0000);
		run <= 1'b1;
		gap(bit_tick, bit_tick, n);
		gap(bit_tick, bit_tick, n);
		chk({n[7:0], sck_oe, mst}, {8'h0A, 2'b00});
		// Framed slave sees sync on the select pin
		sync_req <= 1'b1;
		// Two synchroniser stages, then a one-cycle edge pulse
		repeat (3) @(posedge pclk);
		chk(fs_seen, 1'b1);
		chk(sel_oe, 1'b0);
		@(posedge pclk);
		chk(fs_seen, 1'b0);
		sync_req <= 1'b0;
		run <= 1'b0;
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(0, scp_pkg::CTL_TWO_OFFSET, 0);
		chk(rd, 32'h0000_0000);
		chk({sck_oe, sel_oe, mst, ebuf}, 4'h0);
		chk({sel_out, sck_out, out_en, edge_eff}, 4'hA);
		chk({pready, pslverr}, 2'b10);
		report_and_stop();
	end
endmodule // tb_spi_clock_prescale_and_framing
